// >>> rtl/bbl_consts.vh
// Constants for the burst read boundary latency logic
`ifndef BBL_CONSTS_VH
`define BBL_CONSTS_VH
// Widths
`define BBL_ADDR_W        24
`define BBL_DATA_W        16
`define BBL_CODE_W        4
`define BBL_CNT_W         5
// Configuration field position in the address bus, reset and highest code
`define BBL_CFG_LSB       11
`define BBL_CFG_MSB       14
`define BBL_CODE_RST      4'hA
`define BBL_CODE_MAX      4'hA
// Latency arithmetic
`define BBL_LAT_BASE      5'h04
`define BBL_GROUP         5'h10
`define BBL_EXTRA_MAX     5'h0D
`define BBL_BOUND_LOW     4'hF
`define BBL_ZERO_ADDR     24'h000000
// Data buffer
`define BBL_FIFO_DEPTH    16
`define BBL_FIFO_AW       4
// Burst states
`define BBL_ST_IDLE       2'h0
`define BBL_ST_ADDR       2'h1
`define BBL_ST_LAT        2'h2
`define BBL_ST_DATA       2'h3
`endif

// >>> rtl/bbl_burst_latency.v
// Burst read timing with first word boundary wait insertion, plus its data FIFO
// Behaviour
// - Extra waits only at first boundary crossing
// - Extra count zero to thirteen, address and code
// - Code selects first data edge, 4th to 14th
// - Residue 15, code 0011: six extra cycles
// - Residue 15, code 0010: five extra cycles
// - Start residue is low four address bits
// - Boundary every 16 words, low bits ones
// - Address zero also counts as boundary
// - Code loaded from address bits 14 to 11
`timescale 1ns/1ps
`include "bbl_consts.vh"

module bbl_fifo #(
  parameter W     = `BBL_DATA_W,
  parameter DEPTH = `BBL_FIFO_DEPTH,
  parameter AW    = `BBL_FIFO_AW
) (
  // Clock and control
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  input  wire          flush,
  // Filling side
  input  wire          inValid,
  output wire          inReady,
  input  wire [W-1:0]  inData,
  // Draining side
  output wire          outValid,
  input  wire          outReady,
  output wire [W-1:0]  outData
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0]   count_r;
  wire         push;
  wire         pop;

  // Count tells full from empty when pointers meet
  assign inReady  = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage write, no reset needed for data
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers and fill level
  always @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wrPtr_r <= {AW{1'b0}};
        rdPtr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wrPtr_r <= wrPtr_r + 1'b1;
        end
        if (pop) begin
          rdPtr_r <= rdPtr_r + 1'b1;
        end
        if (push && !pop) begin
          count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
          count_r <= count_r - 1'b1;
        end
      end
    end
  end
endmodule // bbl_fifo

module bbl_burst_latency #(
  parameter AW = `BBL_ADDR_W,
  parameter DW = `BBL_DATA_W
) (
  // Clock, reset, enable
  input  wire          clk,
  input  wire          rst_n,
  input  wire          ce,
  // Host pins
  input  wire          burstClkPin,
  input  wire          addressValidStrobe_n,
  input  wire          chipSel_n,
  input  wire          outEnable_n,
  input  wire          cfgLoad_n,
  input  wire [AW-1:0] addrPin,
  // Data and ready pins
  output reg  [DW-1:0] dqOut,
  output reg           dqOe,
  output reg           rdyOut,
  // Array read port
  output reg  [AW-1:0] arrAddr,
  output reg           arrReq,
  input  wire [DW-1:0] arrData,
  input  wire          arrValid,
  // Status
  output reg  [3:0]    latCode,
  output reg           waitActive
);
  // First data edge index after the strobe returns high
  function [4:0] firstEdge;
    input [3:0] code;
    begin
      if (code > `BBL_CODE_MAX) begin
        firstEdge = `BBL_LAT_BASE + {1'b0, `BBL_CODE_MAX};
      end else begin
        firstEdge = `BBL_LAT_BASE + {1'b0, code};
      end
    end
  endfunction

  // Extra waits: residue + edge - 16, floored at zero, capped at 13
  function [4:0] extraWaits;
    input [3:0] residue;
    input [3:0] code;
    reg   [5:0] sum;
    begin
      sum = {2'b00, residue} + {1'b0, firstEdge(code)};
      if (sum <= {1'b0, `BBL_GROUP}) begin
        extraWaits = 5'h00;
      end else if (sum[4:0] - `BBL_GROUP > `BBL_EXTRA_MAX) begin
        extraWaits = `BBL_EXTRA_MAX;
      end else begin
        extraWaits = sum[4:0] - `BBL_GROUP;
      end
    end
  endfunction

  // Pin synchronisers, two flops each
  reg [AW-1:0] addrS1_r, addrS2_r;
  reg [4:0]    ctlS1_r, ctlS2_r;
  reg          clkPrev_r;
  reg          cfgPrev_r;
  wire         clkS  = ctlS2_r[0];
  wire         strbS = ctlS2_r[1];
  wire         csS   = ctlS2_r[2];
  wire         oeS   = ctlS2_r[3];
  wire         cfgS  = ctlS2_r[4];
  wire         activeEdge = clkS & ~clkPrev_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      addrS1_r  <= {AW{1'b0}};
      addrS2_r  <= {AW{1'b0}};
      ctlS1_r   <= 5'h1E;
      ctlS2_r   <= 5'h1E;
      clkPrev_r <= 1'b0;
      cfgPrev_r <= 1'b1;
    end else if (ce) begin
      addrS1_r  <= addrPin;
      addrS2_r  <= addrS1_r;
      ctlS1_r   <= {cfgLoad_n, outEnable_n, chipSel_n, addressValidStrobe_n, burstClkPin};
      ctlS2_r   <= ctlS1_r;
      clkPrev_r <= clkS;
      cfgPrev_r <= cfgS;
    end
  end

  // Configuration capture at the end of the load strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      latCode <= `BBL_CODE_RST;
    end else if (ce && cfgS && !cfgPrev_r) begin
      latCode <= addrS2_r[`BBL_CFG_MSB:`BBL_CFG_LSB];
    end
  end

  // Burst sequencing state
  reg [1:0]    state_r;
  reg [4:0]    edgeCnt_r;
  reg [4:0]    waitCnt_r;
  reg [4:0]    extra_r;
  reg [4:0]    lat_r;
  reg [AW-1:0] outAddr_r;
  reg          firstDone_r;
  reg          flush_r;
  wire         fifoValid;
  wire         fifoInReady;
  wire [DW-1:0] fifoData;
  wire         inBurst    = (state_r == `BBL_ST_DATA);
  wire         popNow     = activeEdge & inBurst & (waitCnt_r == 5'h00) & fifoValid & ~csS;
  wire         firstNow   = (state_r == `BBL_ST_LAT) & activeEdge & strbS
                            & (edgeCnt_r + 5'h01 == lat_r);
  wire         popAny     = popNow | (firstNow & fifoValid);
  wire         atBoundary = (outAddr_r[3:0] == `BBL_BOUND_LOW);

  always @(posedge clk) begin
    if (!rst_n) begin
      state_r     <= `BBL_ST_IDLE;
      edgeCnt_r   <= 5'h00;
      waitCnt_r   <= 5'h00;
      extra_r     <= 5'h00;
      lat_r       <= `BBL_LAT_BASE;
      outAddr_r   <= {AW{1'b0}};
      firstDone_r <= 1'b0;
      flush_r     <= 1'b0;
      dqOut       <= {DW{1'b0}};
      rdyOut      <= 1'b0;
      waitActive  <= 1'b0;
    end else if (ce) begin
      flush_r <= 1'b0;
      if (csS) begin
        // Deselect ends any burst
        state_r    <= `BBL_ST_IDLE;
        rdyOut     <= 1'b0;
        waitActive <= 1'b0;
      end else if (activeEdge && !strbS) begin
        // Strobe low on an active edge starts a new burst
        state_r     <= `BBL_ST_ADDR;
        outAddr_r   <= addrS2_r;
        extra_r     <= extraWaits(addrS2_r[3:0], latCode);
        lat_r       <= firstEdge(latCode);
        firstDone_r <= (addrS2_r == `BBL_ZERO_ADDR);
        edgeCnt_r   <= 5'h00;
        waitCnt_r   <= 5'h00;
        flush_r     <= 1'b1;
        rdyOut      <= 1'b0;
        waitActive  <= 1'b0;
      end else begin
        case (state_r)
          `BBL_ST_IDLE: begin
            rdyOut <= 1'b0;
          end
          `BBL_ST_ADDR: begin
            // Strobe seen high: this edge is number one
            if (activeEdge) begin
              edgeCnt_r <= 5'h01;
              state_r   <= `BBL_ST_LAT;
            end
          end
          `BBL_ST_LAT: begin
            if (firstNow) begin
              state_r <= `BBL_ST_DATA;
            end else if (activeEdge) begin
              edgeCnt_r <= edgeCnt_r + 5'h01;
            end
          end
          `BBL_ST_DATA: begin
            if (activeEdge && waitCnt_r != 5'h00) begin
              waitCnt_r <= waitCnt_r - 5'h01;
            end
          end
          default: begin
            state_r <= `BBL_ST_IDLE;
          end
        endcase
        // Word presentation and first crossing wait load
        if (popAny) begin
          dqOut      <= fifoData;
          rdyOut     <= 1'b1;
          waitActive <= 1'b0;
          outAddr_r  <= outAddr_r + 1'b1;
          if (atBoundary && !firstDone_r) begin
            firstDone_r <= 1'b1;
            waitCnt_r   <= extra_r;
          end
        end else if (activeEdge && (inBurst || firstNow)) begin
          // Waiting on a crossing or on an empty buffer
          rdyOut     <= 1'b0;
          waitActive <= 1'b1;
        end
      end
    end
  end

  // Output enable follows the host output enable pin during data phase
  always @(posedge clk) begin
    if (!rst_n) begin
      dqOe <= 1'b0;
    end else if (ce) begin
      dqOe <= ~oeS & ~csS & inBurst;
    end
  end

  // Array prefetch; request drops a cycle after each word so stale data is never taken
  wire arrTake = arrReq & arrValid & fifoInReady & ~flush_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      arrAddr <= {AW{1'b0}};
      arrReq  <= 1'b0;
    end else if (ce) begin
      if (flush_r) begin
        arrAddr <= outAddr_r;
        arrReq  <= 1'b0;
      end else if (arrTake) begin
        arrAddr <= arrAddr + 1'b1;
        arrReq  <= 1'b0;
      end else begin
        arrReq  <= (state_r != `BBL_ST_IDLE) & fifoInReady & ~csS;
      end
    end
  end

  // Data buffer; a slow host stalls prefetch through its ready
  bbl_fifo #(
    .W     (DW),
    .DEPTH (`BBL_FIFO_DEPTH),
    .AW    (`BBL_FIFO_AW)
  ) uFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .flush    (flush_r),
    .inValid  (arrTake),
    .inReady  (fifoInReady),
    .inData   (arrData),
    .outValid (fifoValid),
    .outReady (popAny),
    .outData  (fifoData)
  );
endmodule // bbl_burst_latency

// >>> tb/bbl_props.sv
// Checker for wait insertion as seen at the device pins
`timescale 1ns/1ps
module bbl_props (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Host side
  input wire        burstClkPin,
  input wire        addressValidStrobe_n,
  input wire        chipSel_n,
  input wire        cfgLoad_n,
  input wire [23:0] addrPin,
  // Device side
  input wire [15:0] dqOut,
  input wire        dqOe,
  input wire        rdyOut,
  input wire        waitActive,
  input wire [3:0]  latCode,
  input wire [23:0] arrAddr,
  input wire        arrReq,
  input wire        arrValid
);
  reg [3:0] edgeAge_r;
  reg       pinOld_r;
  // Cycles since the burst clock pin rose; outputs may only move soon after
  always @(posedge clk) begin
    pinOld_r <= burstClkPin;
    if (!rst_n || (burstClkPin && !pinOld_r))
      edgeAge_r <= 4'h0;
    else if (edgeAge_r != 4'hF)
      edgeAge_r <= edgeAge_r + 4'h1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Code applies only after its load strobe ends
  // Two sync flops plus the capture flop: code visible three cycles on
  property codeLoadP;
    $rose(cfgLoad_n) |-> ##3 latCode == $past(addrPin[14:11], 3);
  endproperty
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_n |=> !rdyOut && !dqOe && !arrReq && latCode == 4'hA) else $error("reset left state");
  a_code_load: assert property (codeLoadP)
    else $error("code not loaded");
  a_word_or_wait: assert property (rdyOut |-> !waitActive)
    else $error("word and wait together");
  a_data_edge: assert property (!chipSel_n && $changed(dqOut) |-> edgeAge_r <= 4'h6)
    else $error("data moved off an edge");
  a_ready_edge: assert property (!chipSel_n && $changed(rdyOut) |-> edgeAge_r <= 4'h6)
    else $error("ready moved off an edge");
  a_ready_stands: assert property ($rose(rdyOut) |=> rdyOut [*3])
    else $error("ready did not stand");
  a_fetch_step: assert property (addressValidStrobe_n [*6] ##0 (arrReq && arrValid && !chipSel_n)
    |=> !arrReq && arrAddr == $past(arrAddr) + 24'h000001) else $error("fetch did not step");
  a_idle_quiet: assert property (chipSel_n [*5] |-> !dqOe)
    else $error("driving while deselected");
  c_word: cover property ($rose(rdyOut));
  c_wait: cover property ($rose(waitActive));
  c_fetch: cover property (arrReq && arrValid);
endmodule // bbl_props

bind bbl_burst_latency bbl_props u_props (.*);

// >>> tb/bbl_host_model.sv
// Host controller model driving config loads and bursts
`timescale 1ns/1ps
module bbl_host_model (
  // Clock and device outputs
  input  wire        clk,
  input  wire        rdyOut,
  input  wire [15:0] dqOut,
  input  wire        waitActive,
  input  wire        dqOe,
  // Host pins
  output reg         burstClkPin,
  output reg         addressValidStrobe_n,
  output reg         chipSel_n,
  output reg         outEnable_n,
  output reg         cfgLoad_n,
  output reg  [23:0] addrPin
);
  reg        gotQ[$];
  reg [15:0] datQ[$];
  reg        waitQ[$];
  reg        oeQ[$];
  // Deselected, burst clock parked low between frames
  initial begin
    {burstClkPin, addressValidStrobe_n, chipSel_n, outEnable_n, cfgLoad_n} = 5'h0F;
    addrPin = 24'h000000;
  end
  // Load code, run n edges; each result is sampled just before the next edge
  task automatic run(input reg [23:0] a, input reg [3:0] code, input integer n);
    integer i;
    addrPin   = {9'h000, code, 11'h000};
    cfgLoad_n = 1'b0;
    repeat (4) @(negedge clk);
    cfgLoad_n = 1'b1;
    repeat (8) @(negedge clk);
    gotQ.delete();
    datQ.delete();
    waitQ.delete();
    oeQ.delete();
    {chipSel_n, outEnable_n, addressValidStrobe_n} = 3'h0;
    addrPin = a;
    for (i = 0; i < n; i = i + 1) begin
      burstClkPin = 1'b1;
      repeat (4) @(negedge clk);
      burstClkPin          = 1'b0;
      addressValidStrobe_n = 1'b1;
      addrPin              = ~a; // Inverted after the edge, so a stale address shows
      repeat (3) @(negedge clk);
      gotQ.push_back(rdyOut);
      datQ.push_back(dqOut);
      waitQ.push_back(waitActive);
      oeQ.push_back(dqOe);
      @(negedge clk);
    end
    {chipSel_n, outEnable_n} = 2'h3;
    repeat (8) @(negedge clk);
  endtask
endmodule // bbl_host_model

// >>> tb/test_bbl_burst_latency.sv
// Self-checking bench for burst wait insertion
`timescale 1ns/1ps
module test_bbl_burst_latency;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         ce = 1'b1;
  reg         arrValid = 1'b0;
  reg  [15:0] arrData = 16'h0000;
  wire        burstClkPin, addressValidStrobe_n, chipSel_n, outEnable_n, cfgLoad_n;
  wire        dqOe, rdyOut, arrReq, waitActive;
  wire [23:0] addrPin, arrAddr;
  wire [15:0] dqOut;
  wire [3:0]  latCode;
  integer     numErrors = 0;
  integer     cmpCount = 0;

  bbl_burst_latency u_dut (.*);
  bbl_host_model u_host (.*);

  // 50 MHz system clock
  always #10 clk = ~clk;
  // Array answers every other cycle, so fetches see stalls
  always @(negedge clk) begin
    arrValid <= ~arrValid;
    arrData  <= arrAddr[15:0] ^ 16'h5A5A;
  end

  task automatic check(input string what, input reg [15:0] exp, input reg [15:0] got);
    cmpCount = cmpCount + 1;
    if (got !== exp) begin
      numErrors = numErrors + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One burst judged edge by edge against the wait arithmetic
  task automatic burst_chk(input reg [23:0] a, input reg [3:0] code);
    integer i, lat, ext, w;
    reg [23:0] wa;
    reg        crossed;
    reg        want;
    u_host.run(a, code, 44);
    lat     = code + 4;
    ext     = lat + a[3:0];
    ext     = (ext > 16) ? ext - 16 : 0;
    w       = 0;
    wa      = a;
    crossed = (a == 24'h000000);
    for (i = 1; i < 44; i = i + 1) begin
      want = (i >= lat) && (w == 0);
      if (i >= lat && w > 0)
        w = w - 1;
      check("ready", {15'h0000, want}, {15'h0000, u_host.gotQ[i]});
      check("wait", {15'h0000, (i >= lat) && !want}, {15'h0000, u_host.waitQ[i]});
      check("drive", {15'h0000, (i >= lat)}, {15'h0000, u_host.oeQ[i]});
      if (want) begin
        check("data", wa[15:0] ^ 16'h5A5A, u_host.datQ[i]);
        if (wa[3:0] == 4'hF && !crossed) begin
          crossed = 1'b1;
          w       = ext;
        end
        wa = wa + 24'h000001;
      end
    end
  endtask
  // Pins and code straight after reset
  task automatic t_reset_values();
    check("code", 16'h000A, {12'h000, latCode});
    check("drive", 16'h0000, {14'h0000, dqOe, rdyOut});
  endtask
  // Worst residue at two codes, run past the second boundary
  task automatic t_worst_case();
    burst_chk(24'h00ABCF, 4'h3);
    burst_chk(24'h3FFFEF, 4'h2);
  endtask
  // Every residue against the four tabled codes
  task automatic t_residue_table();
    integer c, r;
    for (c = 0; c < 4; c = c + 1)
      for (r = 0; r < 16; r = r + 1)
        burst_chk({20'h01234, r[3:0]}, (c == 3) ? 4'hA : c[3:0]);
  endtask
  // Start on address zero
  task automatic t_zero_start();
    burst_chk(24'h000000, 4'hA);
  endtask
  task automatic giveVerdict();
    if (numErrors == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset_values();
    t_worst_case();
    t_residue_table();
    t_zero_start();
    giveVerdict();
  end
  // Watchdog well past the half millisecond the bursts need
  initial begin
    #1000000;
    numErrors = numErrors + 1;
    giveVerdict();
  end
endmodule // test_bbl_burst_latency
